//--- rtl/fsfe_regs.svh
// constants of the file-system front end: offsets, fields, codes, disk layout
`ifndef FSFE_REGS_SVH
`define FSFE_REGS_SVH

// ------------------------------------------------------------
// register map (byte addresses on the bus)
// ------------------------------------------------------------
`define FSFE_ADDR_CTRL       8'h00
`define FSFE_ADDR_STATUS     8'h04
`define FSFE_ADDR_CAPACITY   8'h08
`define FSFE_CTRL_HOLD_BIT   0
`define FSFE_CTRL_RESET      32'h0000_0000
`define FSFE_STAT_BUSY_BIT   0
`define FSFE_STAT_ERR_BIT    1
`define FSFE_STAT_STATE_LSB  4
`define FSFE_STAT_STATE_MSB  7

// ------------------------------------------------------------
// user command and file size codes
// ------------------------------------------------------------
`define FSFE_UCMD_FORMAT     2'b00
`define FSFE_UCMD_RESERVED   2'b01
`define FSFE_UCMD_WRITE      2'b10
`define FSFE_UCMD_READ       2'b11
`define FSFE_FILE_SIZE_SELECT_RESERVED  3'h7

// ------------------------------------------------------------
// host core command codes (value choices of this block)
// ------------------------------------------------------------
`define FSFE_HCMD_IDENTIFY   2'b00
`define FSFE_HCMD_WRITE      2'b10
`define FSFE_HCMD_READ       2'b11

// ------------------------------------------------------------
// disk layout in 512-byte sectors
// ------------------------------------------------------------
`define FSFE_MB_LOG2         5'd20
`define FSFE_SECTOR_LOG2     5'd9
`define FSFE_MIN_SIZE_LOG2   5'd5
`define FSFE_SYS_SECTORS     48'h0000_0000_8000
`define FSFE_DIR_BASE        48'h0000_0000_4000
`define FSFE_DATA_BASE       48'h0000_0000_8000
`define FSFE_FMT_SECTORS     48'h0000_0000_0008
`define FSFE_HDR_SECTORS     48'h0000_0000_0001
`define FSFE_FMT_WORDS       16'h0400
`define FSFE_HDR_WORDS       16'h0080
`define FSFE_FMT_FILL        32'h0000_0000
`define FSFE_TEST_POINTS     64'h0000_0000_0000_0000
`define FSFE_RX_FULL_MASK    13'h1fff

`endif

//--- rtl/fsfe_pkg.sv
// types of the file-system front end
package fsfe_pkg;

  // gray codes along init -> idle -> command -> header; the returns to idle change two bits
  typedef enum logic [3:0] {
    ST_INIT    = 4'h0,
    ST_ID_REQ  = 4'h1,
    ST_ID_RUN  = 4'h3,
    ST_CALC    = 4'h2,
    ST_IDLE    = 4'h6,
    ST_CMD_REQ = 4'h7,
    ST_CMD_RUN = 4'h5,
    ST_HDR_REQ = 4'h4,
    ST_HDR_RUN = 4'hc
  } fsfe_state_t;

  typedef enum logic [1:0] {
    OP_FORMAT = 2'b00,
    OP_NONE   = 2'b01,
    OP_WRITE  = 2'b10,
    OP_READ   = 2'b11
  } fsfe_op_t;

  typedef struct packed {
    logic [1:0]  cmd;
    logic [47:0] addr;
    logic [47:0] len;
  } fsfe_host_cmd_t;

  typedef struct packed {
    logic [6:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [4:0] two_sec;
  } fsfe_stamp_t;

endpackage

//--- rtl/fsfe_wb_regs.sv
// classic wishbone slave holding the control, status and capacity words
`include "fsfe_regs.svh"
module fsfe_wb_regs (
  input  wire logic        clk_sys,
  input  wire logic        reset_low,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_cyc_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        stat_busy,
  input  wire logic        stat_error,
  input  wire logic [3:0]  stat_state,
  input  wire logic [15:0] stat_capacity,
  output logic             ctrl_hold
);

  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] rdata_q, rdata_d;
  logic        ack_q, ack_d;
  logic        take;

  // one access per request; ack drops the cycle after it rose
  assign take = wb_cyc_i && wb_stb_i && !ack_q;

  always_comb begin
    ctrl_d  = ctrl_q;
    rdata_d = rdata_q;
    ack_d   = take;
    if (take) begin
      rdata_d = 32'h0000_0000;
      case (wb_adr_i)
        `FSFE_ADDR_CTRL: begin
          rdata_d = ctrl_q;
          if (wb_we_i && wb_sel_i[0]) begin
            ctrl_d[`FSFE_CTRL_HOLD_BIT] = wb_dat_i[`FSFE_CTRL_HOLD_BIT];
          end
        end
        `FSFE_ADDR_STATUS: begin
          rdata_d[`FSFE_STAT_BUSY_BIT] = stat_busy;
          rdata_d[`FSFE_STAT_ERR_BIT]  = stat_error;
          rdata_d[`FSFE_STAT_STATE_MSB:`FSFE_STAT_STATE_LSB] = stat_state;
        end
        `FSFE_ADDR_CAPACITY: rdata_d[15:0] = stat_capacity;
        // unmapped: acked, reads zero, writes dropped
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_low) begin
      ctrl_q  <= `FSFE_CTRL_RESET;
      rdata_q <= 32'h0000_0000;
      ack_q   <= 1'b0;
    end else begin
      ctrl_q  <= ctrl_d;
      rdata_q <= rdata_d;
      ack_q   <= ack_d;
    end
  end

  assign wb_dat_o  = rdata_q;
  assign wb_ack_o  = ack_q;
  assign ctrl_hold = ctrl_q[`FSFE_CTRL_HOLD_BIT];

endmodule

//--- rtl/fsfe_top.sv
// file-system front end: file commands in, sector commands and fifo data out
//
// What this block does
// - active-low reset sampled on clock edge
// - size select codes 32MB..2048MB, 111 reserved
// - megabyte is 1024 times 1024 bytes
// - year input counts from 1980
// - month, day, hour, minute, two-second fields accepted
// - command 00 format, 10 write, 11 read
// - busy high while working, requests refused
// - file capacity output valid after initialization
// - host error flag and kind passed through
// - receive push only if count[15:3] not ones
// - transmit level ignored, empty flag decides
// - receive word valid with its push strobe
// - sector command, address, length, request to host
// - act as fifo pair toward host core
// - pop user data only while not empty
// - busy from reset until initialization completes
// - format ignores first index and file count
//
// The implementer's own choices: the register addresses and the Wishbone register port.
`include "fsfe_regs.svh"
module fsfe_top (
  input  wire logic        clk_sys,
  input  wire logic        reset_low,
  input  wire logic [2:0]  file_size_select,
  input  wire logic [6:0]  create_year,
  input  wire logic [3:0]  create_month,
  input  wire logic [4:0]  create_day,
  input  wire logic [4:0]  create_hour,
  input  wire logic [5:0]  create_minute,
  input  wire logic [4:0]  create_two_seconds,
  input  wire logic [1:0]  file_command,
  input  wire logic [15:0] first_file_index,
  input  wire logic [15:0] file_count,
  input  wire logic        command_request,
  output logic             engine_busy,
  output logic      [15:0] file_capacity,
  output logic             error_flag_out,
  output logic      [31:0] error_kind_out,
  output logic      [63:0] test_points,
  input  wire logic [15:0] rx_fifo_fill_count,
  output logic             rx_fifo_push,
  output logic      [31:0] rx_fifo_push_word,
  input  wire logic [15:0] tx_fifo_level,
  input  wire logic        tx_fifo_empty,
  output logic             tx_fifo_pop,
  input  wire logic [31:0] tx_fifo_pop_word,
  output logic      [1:0]  host_command_out,
  output logic      [47:0] host_sector_address,
  output logic      [47:0] host_sector_length,
  output logic             host_request_out,
  input  wire logic        host_busy_in,
  input  wire logic [47:0] host_disk_capacity,
  input  wire logic        host_error_in,
  input  wire logic [31:0] host_error_kind_in,
  output logic      [15:0] host_side_rx_count,
  input  wire logic        host_side_rx_push,
  input  wire logic [31:0] host_side_rx_word,
  output logic      [15:0] host_side_tx_level,
  output logic             host_side_tx_empty,
  input  wire logic        host_side_tx_pop,
  output logic      [31:0] host_side_tx_word,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_cyc_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  fsfe_pkg::fsfe_state_t    state_q, state_d;
  fsfe_pkg::fsfe_op_t       op_q, op_d;
  fsfe_pkg::fsfe_host_cmd_t hcmd_q, hcmd_d;
  fsfe_pkg::fsfe_stamp_t    stamp_now;
  logic [47:0]              disk_cap_q, disk_cap_d;
  logic [15:0]              fcap_q, fcap_d;
  logic [15:0]              sys_words_q, sys_words_d;
  logic [31:0]              sys_word_q, sys_word_d;
  logic                     rx_push_q, rx_push_d;
  logic [31:0]              rx_word_q, rx_word_d;
  logic                     ctrl_hold;

  // ------------------------------------------------------------
  // size arithmetic
  // ------------------------------------------------------------
  logic [4:0]  file_shift;
  logic [47:0] user_area;
  logic [47:0] files_fit;
  logic [15:0] fcap_calc;
  logic        size_ok;
  logic        cmd_ok;
  logic [47:0] user_addr;
  logic [47:0] user_len;
  logic [47:0] dir_addr;
  logic        user_wr_phase;
  logic        rd_phase;
  logic        sys_phase;
  logic        in_cmd;
  logic        rx_has_room;

  // sectors per file = 2^(20 - 9 + 5 + code): binary megabyte
  assign file_shift = `FSFE_MB_LOG2 - `FSFE_SECTOR_LOG2 + `FSFE_MIN_SIZE_LOG2
                      + {2'b00, file_size_select};
  assign size_ok    = (file_size_select != `FSFE_FILE_SIZE_SELECT_RESERVED);
  assign cmd_ok     = (file_command != `FSFE_UCMD_RESERVED);
  assign user_area  = (disk_cap_q > `FSFE_SYS_SECTORS) ?
                      (disk_cap_q - `FSFE_SYS_SECTORS) : 48'h0;
  assign files_fit  = user_area >> file_shift;
  // saturate; reserved size reports no room at all
  assign fcap_calc  = !size_ok ? 16'h0000 :
                      (|files_fit[47:16]) ? 16'hffff : files_fit[15:0];
  assign user_addr  = `FSFE_DATA_BASE + ({32'h0, first_file_index} << file_shift);
  assign user_len   = {32'h0, file_count} << file_shift;
  // one directory sector holds 16 entries
  assign dir_addr   = `FSFE_DIR_BASE + {36'h0, first_file_index[15:4]};

  // packed fat-style stamp: date in the high half, time in the low half
  assign stamp_now = '{year:    create_year,
                       month:   create_month,
                       day:     create_day,
                       hour:    create_hour,
                       minute:  create_minute,
                       two_sec: create_two_seconds};

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_d     = state_q;
    op_d        = op_q;
    hcmd_d      = hcmd_q;
    disk_cap_d  = disk_cap_q;
    fcap_d      = fcap_q;
    sys_words_d = sys_words_q;
    case (state_q)
      fsfe_pkg::ST_INIT: begin
        // host core still bringing up the link
        if (!host_busy_in) begin
          hcmd_d  = '{cmd: `FSFE_HCMD_IDENTIFY, addr: 48'h0, len: `FSFE_HDR_SECTORS};
          state_d = fsfe_pkg::ST_ID_REQ;
        end
      end
      fsfe_pkg::ST_ID_REQ: begin
        if (host_busy_in) begin
          state_d = fsfe_pkg::ST_ID_RUN;
        end
      end
      fsfe_pkg::ST_ID_RUN: begin
        if (!host_busy_in) begin
          disk_cap_d = host_disk_capacity;
          state_d    = fsfe_pkg::ST_CALC;
        end
      end
      fsfe_pkg::ST_CALC: begin
        fcap_d  = fcap_calc;
        state_d = fsfe_pkg::ST_IDLE;
      end
      fsfe_pkg::ST_IDLE: begin
        // capacity follows a size change without a new identify
        fcap_d = fcap_calc;
        if (command_request && cmd_ok && size_ok) begin
          state_d = fsfe_pkg::ST_CMD_REQ;
          case (file_command)
            `FSFE_UCMD_FORMAT: begin
              // index and count play no part here
              op_d        = fsfe_pkg::OP_FORMAT;
              hcmd_d      = '{cmd: `FSFE_HCMD_WRITE, addr: 48'h0,
                              len: `FSFE_FMT_SECTORS};
              sys_words_d = `FSFE_FMT_WORDS;
            end
            `FSFE_UCMD_WRITE: begin
              op_d   = fsfe_pkg::OP_WRITE;
              hcmd_d = '{cmd: `FSFE_HCMD_WRITE, addr: user_addr, len: user_len};
            end
            `FSFE_UCMD_READ: begin
              op_d   = fsfe_pkg::OP_READ;
              hcmd_d = '{cmd: `FSFE_HCMD_READ, addr: user_addr, len: user_len};
            end
            default: begin
              op_d    = fsfe_pkg::OP_NONE;
              state_d = fsfe_pkg::ST_IDLE;
            end
          endcase
        end
      end
      fsfe_pkg::ST_CMD_REQ: begin
        if (host_busy_in) begin
          state_d = fsfe_pkg::ST_CMD_RUN;
        end
      end
      fsfe_pkg::ST_CMD_RUN: begin
        if (!host_busy_in) begin
          if (op_q == fsfe_pkg::OP_WRITE) begin
            // header last, so a power loss leaves no half-made file
            hcmd_d      = '{cmd: `FSFE_HCMD_WRITE, addr: dir_addr,
                            len: `FSFE_HDR_SECTORS};
            sys_words_d = `FSFE_HDR_WORDS;
            state_d     = fsfe_pkg::ST_HDR_REQ;
          end else begin
            state_d = fsfe_pkg::ST_IDLE;
          end
        end
      end
      fsfe_pkg::ST_HDR_REQ: begin
        if (host_busy_in) begin
          state_d = fsfe_pkg::ST_HDR_RUN;
        end
      end
      fsfe_pkg::ST_HDR_RUN: begin
        if (!host_busy_in) begin
          op_d    = fsfe_pkg::OP_NONE;
          state_d = fsfe_pkg::ST_IDLE;
        end
      end
      default: state_d = fsfe_pkg::ST_INIT;
    endcase
    // system words leave one per host pop
    if (sys_phase && host_side_tx_pop && (sys_words_q != 16'h0000)) begin
      sys_words_d = sys_words_q - 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // data paths
  // ------------------------------------------------------------
  assign in_cmd        = (state_q == fsfe_pkg::ST_CMD_REQ) ||
                         (state_q == fsfe_pkg::ST_CMD_RUN);
  assign user_wr_phase = in_cmd && (op_q == fsfe_pkg::OP_WRITE);
  assign rd_phase      = in_cmd && (op_q == fsfe_pkg::OP_READ);
  assign sys_phase     = (in_cmd && (op_q == fsfe_pkg::OP_FORMAT)) ||
                         (state_q == fsfe_pkg::ST_HDR_REQ) ||
                         (state_q == fsfe_pkg::ST_HDR_RUN);
  assign rx_has_room   = (rx_fifo_fill_count[15:3] != `FSFE_RX_FULL_MASK);

  always_comb begin
    rx_push_d  = rd_phase && host_side_rx_push && rx_has_room;
    rx_word_d  = host_side_rx_push ? host_side_rx_word : rx_word_q;
    sys_word_d = (op_q == fsfe_pkg::OP_FORMAT) ? `FSFE_FMT_FILL
                                                : 32'(stamp_now);
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_low) begin
      state_q     <= fsfe_pkg::ST_INIT;
      op_q        <= fsfe_pkg::OP_NONE;
      hcmd_q      <= '0;
      disk_cap_q  <= 48'h0;
      fcap_q      <= 16'h0000;
      sys_words_q <= 16'h0000;
      sys_word_q  <= 32'h0000_0000;
      rx_push_q   <= 1'b0;
      rx_word_q   <= 32'h0000_0000;
    end else begin
      state_q     <= state_d;
      op_q        <= op_d;
      hcmd_q      <= hcmd_d;
      disk_cap_q  <= disk_cap_d;
      fcap_q      <= fcap_d;
      sys_words_q <= sys_words_d;
      sys_word_q  <= sys_word_d;
      rx_push_q   <= rx_push_d;
      rx_word_q   <= rx_word_d;
    end
  end

  // ------------------------------------------------------------
  // user side outputs
  // ------------------------------------------------------------
  assign engine_busy       = (state_q != fsfe_pkg::ST_IDLE);
  assign file_capacity     = fcap_q;
  assign error_flag_out    = host_error_in;
  assign error_kind_out    = host_error_kind_in;
  assign test_points       = `FSFE_TEST_POINTS;
  assign rx_fifo_push      = rx_push_q;
  assign rx_fifo_push_word = rx_word_q;
  // the level input is never looked at
  assign tx_fifo_pop       = user_wr_phase && host_side_tx_pop &&
                             !tx_fifo_empty && !ctrl_hold;

  // ------------------------------------------------------------
  // host side outputs
  // ------------------------------------------------------------
  assign host_command_out    = hcmd_q.cmd;
  assign host_sector_address = hcmd_q.addr;
  assign host_sector_length  = hcmd_q.len;
  assign host_request_out    = (state_q == fsfe_pkg::ST_ID_REQ) ||
                               (state_q == fsfe_pkg::ST_CMD_REQ) ||
                               (state_q == fsfe_pkg::ST_HDR_REQ);
  // identify data is swallowed, so report room outside reads
  assign host_side_rx_count  = !rd_phase ? 16'h0000 :
                               ctrl_hold ? 16'hffff : rx_fifo_fill_count;
  assign host_side_tx_empty  = user_wr_phase ? (tx_fifo_empty || ctrl_hold) :
                               sys_phase ? (sys_words_q == 16'h0000) : 1'b1;
  assign host_side_tx_level  = user_wr_phase ? {15'h0000, !host_side_tx_empty} :
                               sys_phase ? sys_words_q : 16'h0000;
  // user words come straight from the fifo, already a clock late
  assign host_side_tx_word   = user_wr_phase ? tx_fifo_pop_word : sys_word_q;

  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  fsfe_wb_regs u_regs (
    .clk_sys       (clk_sys),
    .reset_low     (reset_low),
    .wb_adr_i      (wb_adr_i),
    .wb_dat_i      (wb_dat_i),
    .wb_sel_i      (wb_sel_i),
    .wb_we_i       (wb_we_i),
    .wb_stb_i      (wb_stb_i),
    .wb_cyc_i      (wb_cyc_i),
    .wb_dat_o      (wb_dat_o),
    .wb_ack_o      (wb_ack_o),
    .stat_busy     (engine_busy),
    .stat_error    (host_error_in),
    .stat_state    (state_q),
    .stat_capacity (fcap_q),
    .ctrl_hold     (ctrl_hold)
  );

endmodule

//--- test/fsfe_top_sva.sv
// port assertions of the file-system front end
`include "fsfe_regs.svh"
module fsfe_top_sva (
  input wire logic        clk_sys,
  input wire logic        reset_low,
  input wire logic [2:0]  file_size_select,
  input wire logic [1:0]  file_command,
  input wire logic        command_request,
  input wire logic        engine_busy,
  input wire logic [15:0] file_capacity,
  input wire logic        error_flag_out,
  input wire logic [31:0] error_kind_out,
  input wire logic [63:0] test_points,
  input wire logic [15:0] rx_fifo_fill_count,
  input wire logic        rx_fifo_push,
  input wire logic [31:0] rx_fifo_push_word,
  input wire logic        tx_fifo_empty,
  input wire logic        tx_fifo_pop,
  input wire logic [31:0] tx_fifo_pop_word,
  input wire logic [1:0]  host_command_out,
  input wire logic [47:0] host_sector_address,
  input wire logic [47:0] host_sector_length,
  input wire logic        host_request_out,
  input wire logic        host_busy_in,
  input wire logic        host_error_in,
  input wire logic [31:0] host_error_kind_in,
  input wire logic        host_side_rx_push,
  input wire logic [31:0] host_side_rx_word,
  input wire logic        host_side_tx_pop,
  input wire logic [31:0] host_side_tx_word,
  input wire logic        wb_stb_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_ack_o
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_low);
  wire logic take_w = !engine_busy && command_request && file_command != `FSFE_UCMD_RESERVED
    && file_size_select != `FSFE_FILE_SIZE_SELECT_RESERVED;
  a_busy_from_reset: assert property ($rose(reset_low) |-> engine_busy && file_capacity == 16'h0)
    else $error("busy or capacity wrong after reset");
  a_take_sets_busy: assert property (take_w |=> engine_busy && host_request_out)
    else $error("accepted request did not start");
  a_idle_stays: assert property (!engine_busy && !take_w |=> !engine_busy)
    else $error("busy without accepted request");
  a_host_cmd_code: assert property (take_w |=> host_command_out == ($past(file_command[1]) ?
    $past(file_command) : `FSFE_HCMD_WRITE))
    else $error("host command code wrong");
  a_host_req_hold: assert property (host_request_out && !host_busy_in |=> host_request_out
    && $stable(host_sector_address) && $stable(host_sector_length))
    else $error("host request dropped early");
  a_error_pass: assert property (error_flag_out == host_error_in
    && error_kind_out == host_error_kind_in)
    else $error("error outputs differ from host");
  a_test_fixed: assert property (test_points == `FSFE_TEST_POINTS)
    else $error("test points moved");
  a_rx_push_space: assert property (rx_fifo_push |-> $past(host_side_rx_push)
    && $past(rx_fifo_fill_count[15:3]) != `FSFE_RX_FULL_MASK
    && rx_fifo_push_word == $past(host_side_rx_word))
    else $error("receive push without space or word");
  a_tx_pop_avail: assert property (tx_fifo_pop |-> !tx_fifo_empty && host_side_tx_pop)
    else $error("transmit pop while empty");
  a_tx_word_pass: assert property (tx_fifo_pop |=>
    host_side_tx_word == tx_fifo_pop_word)
    else $error("transmit word not passed");
  a_wb_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single pulse");
endmodule
bind fsfe_top fsfe_top_sva u_sva (.*);

//--- test/fsfe_host_model.sv
// host core stand-in: busy handshake and sector data both ways
module fsfe_host_model (
  input  wire logic        clk_sys,
  input  wire logic        reset_low,
  input  wire logic [1:0]  host_command_out,
  input  wire logic        host_request_out,
  output logic             host_busy_in,
  output logic      [47:0] host_disk_capacity,
  output logic             host_side_rx_push,
  output logic      [31:0] host_side_rx_word,
  input  wire logic        host_side_tx_empty,
  output logic             host_side_tx_pop
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  left_q;
  logic [31:0] word_q;
  logic [1:0]  op_q;
  assign host_disk_capacity = 48'h0000_0010_8000;
  // idle bus shows the inverse so a stale word never looks valid
  assign host_side_rx_word = host_side_rx_push ? word_q : ~word_q;
  assign host_side_tx_pop = host_busy_in && op_q == 2'h2 && !host_side_tx_empty;
  always @(posedge clk_sys) begin
    if (!reset_low) begin
      host_busy_in <= 1'h1;
      left_q <= 8'h04;
      op_q <= 2'h0;
      word_q <= 32'h0000_1000;
      host_side_rx_push <= 1'h0;
    end else if (host_busy_in) begin
      left_q <= left_q - 8'h01;
      host_busy_in <= left_q != 8'h00;
      host_side_rx_push <= op_q == 2'h3 && left_q > 8'h02;
      if (op_q == 2'h3 && left_q > 8'h02) begin
        word_q <= word_q + 32'h0000_0001;
      end
    end else if (host_request_out) begin
      host_busy_in <= 1'h1;
      left_q <= 8'h18;
      op_q <= host_command_out;
    end
  end
endmodule

//--- test/test_disk_file_system_front_end.sv
// self-checking bench of the file-system front end
`include "fsfe_regs.svh"
module test_disk_file_system_front_end;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, reset_low, command_request, engine_busy, error_flag_out, host_error_in;
  logic        rx_fifo_push, tx_fifo_pop, host_request_out, host_busy_in;
  logic        host_side_rx_push, host_side_tx_empty, host_side_tx_pop, wb_we_i, wb_stb_i;
  logic        wb_cyc_i, wb_ack_o;
  logic        tx_fifo_empty = 1'h1;
  logic [1:0]  file_command, host_command_out;
  logic [2:0]  file_size_select;
  logic [3:0]  create_month, wb_sel_i;
  logic [4:0]  create_day, create_hour, create_two_seconds;
  logic [5:0]  create_minute;
  logic [6:0]  create_year;
  logic [7:0]  wb_adr_i;
  logic [15:0] first_file_index, file_count, file_capacity, rx_fifo_fill_count, tx_fifo_level;
  logic [15:0] host_side_rx_count, host_side_tx_level;
  logic [31:0] error_kind_out, rx_fifo_push_word, host_error_kind_in, tx_fifo_pop_word = '0;
  logic [31:0] host_side_rx_word, host_side_tx_word, wb_dat_i, wb_dat_o, rd;
  logic [47:0] host_sector_address, host_sector_length, host_disk_capacity;
  logic [63:0] test_points;
  int          fails, cmp_count, pushes, pops, p;
  fsfe_top DUT (.*);
  fsfe_host_model u_host (.*);
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  // user fifos: transmit word lands a cycle after pop, and stalls every other cycle
  always @(posedge clk_sys) begin
    if (tx_fifo_pop) begin
      tx_fifo_pop_word <= tx_fifo_pop_word + 32'h1;
      pops <= pops + 1;
    end
    tx_fifo_empty <= ~tx_fifo_empty;
    if (rx_fifo_push) pushes <= pushes + 1;
  end
  task automatic check(input string what, input logic [63:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic bound(inout int n);
    n++;
    if (n > 2000) begin
      fails++;
      conclude();
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hf;
    do begin
      @(posedge clk_sys);
      bound(n);
    end while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (engine_busy !== lvl) begin
      @(posedge clk_sys);
      bound(n);
    end
  endtask
  task automatic cmd(input logic [1:0] c, input logic [15:0] idx, cnt);
    @(posedge clk_sys);
    file_command <= c;
    first_file_index <= idx;
    file_count <= cnt;
    command_request <= 1'h1;
    @(posedge clk_sys);
    command_request <= 1'h0;
    @(posedge clk_sys);
  endtask
  initial begin
    {reset_low, command_request, host_error_in, wb_we_i, wb_stb_i, wb_cyc_i} = '0;
    {file_command, file_size_select, first_file_index, file_count} = '0;
    {rx_fifo_fill_count, tx_fifo_level, host_error_kind_in} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i, fails, cmp_count, p} = '0;
    // stamp held for every write of the run
    {create_year, create_month, create_day} = {7'h25, 4'h9, 5'h16};
    {create_hour, create_minute, create_two_seconds} = {5'h17, 6'h3b, 5'h1d};
    repeat (3) @(posedge clk_sys);
    reset_low <= 1'h1;
    wait_busy(1'h0);
    check("capacity", file_capacity, 48'h10);
    $display("test init done");
    wb(1'h0, `FSFE_ADDR_CTRL, 32'h0);
    check("ctrl", rd, `FSFE_CTRL_RESET);
    wb(1'h1, `FSFE_ADDR_CTRL, 32'h1);
    wb(1'h0, `FSFE_ADDR_CTRL, 32'h0);
    check("ctrl hold", rd, 48'h1);
    wb(1'h1, `FSFE_ADDR_CTRL, 32'h0);
    wb(1'h0, `FSFE_ADDR_STATUS, 32'h0);
    check("status", rd, {fsfe_pkg::ST_IDLE, 4'h0});
    wb(1'h0, `FSFE_ADDR_CAPACITY, 32'h0);
    check("cap reg", rd, 48'h10);
    wb(1'h0, 8'h0c, 32'h0);
    check("unmapped", rd, 48'h0);
    host_error_in <= 1'h1;
    host_error_kind_in <= 32'hc0de_0042;
    repeat (2) @(posedge clk_sys);
    check("error kind", {error_flag_out, error_kind_out}, 48'h1_c0de_0042);
    host_error_in <= 1'h0;
    $display("test registers done");
    for (int s = 0; s < 8; s++) begin
      file_size_select <= s[2:0];
      repeat (8) @(posedge clk_sys);
      check("size cap", file_capacity, s == 7 ? 48'h0 : 48'h10_0000 >> (16 + s));
    end
    cmd(`FSFE_UCMD_WRITE, 16'h0, 16'h1);
    check("size refused", engine_busy, 48'h0);
    file_size_select <= 3'h0;
    cmd(`FSFE_UCMD_RESERVED, 16'h0, 16'h1);
    check("cmd refused", engine_busy, 48'h0);
    $display("test codes done");
    cmd(`FSFE_UCMD_FORMAT, 16'hffff, 16'h0);
    check("fmt len", {host_command_out, host_sector_length}, {2'h2, `FSFE_FMT_SECTORS});
    wait_busy(1'h0);
    $display("test format done");
    p = pops;
    cmd(`FSFE_UCMD_WRITE, 16'h3, 16'h1);
    check("wr cmd", host_command_out, `FSFE_HCMD_WRITE);
    check("wr addr", host_sector_address, `FSFE_DATA_BASE + 48'h3_0000);
    check("wr len", host_sector_length, 48'h1_0000);
    repeat (4) @(posedge clk_sys);
    wait_busy(1'h0);
    check("tx pops", pops > p, 48'h1);
    $display("test write done");
    cmd(`FSFE_UCMD_READ, 16'h2, 16'h2);
    check("rd cmd", host_command_out, `FSFE_HCMD_READ);
    check("rd addr", host_sector_address, `FSFE_DATA_BASE + 48'h2_0000);
    check("rd len", host_sector_length, 48'h2_0000);
    rx_fifo_fill_count <= 16'hfff8;
    repeat (3) @(posedge clk_sys);
    check("rx count", host_side_rx_count, 48'hfff8);
    p = pushes;
    cmd(`FSFE_UCMD_FORMAT, 16'h0, 16'h0);
    repeat (3) @(posedge clk_sys);
    check("no push full", pushes, p);
    check("busy refuse", host_command_out, `FSFE_HCMD_READ);
    rx_fifo_fill_count <= 16'h0;
    wait_busy(1'h0);
    check("rx pushes", pushes > p, 48'h1);
    $display("test read done");
    conclude();
  end
endmodule
